// ---- acm_defines.svh ----
// register map, field positions, reset values and widths of the converter control block
`ifndef ACM_DEFINES_SVH
`define ACM_DEFINES_SVH

// ------------------------------------------------------------
// register word indices; the byte address is four times the index
// ------------------------------------------------------------
`define ACM_OFS_TIMING     4'h0
`define ACM_OFS_MUX        4'h1
`define ACM_OFS_PINCFG     4'h2
`define ACM_OFS_SCANSEL    4'h3
`define ACM_OFS_MODE       4'h4
`define ACM_OFS_STATUS     4'h5
`define ACM_ADDR_LSB       2
`define ACM_ADDR_MSB       5

// ------------------------------------------------------------
// field positions and masks
// ------------------------------------------------------------
`define ACM_TIM_SRC_BIT    15
`define ACM_TIM_SAMC_MSB   12
`define ACM_TIM_SAMC_LSB   8
`define ACM_TIM_DIV_MSB    7
`define ACM_TIM_DIV_LSB    0
`define ACM_TIM_MASK       16'h9fff
`define ACM_MUX_NB_BIT     15
`define ACM_MUX_SB_MSB     12
`define ACM_MUX_SB_LSB     8
`define ACM_MUX_NA_BIT     7
`define ACM_MUX_SA_MSB     4
`define ACM_MUX_SA_LSB     0
`define ACM_MUX_MASK       16'h9f9f
`define ACM_MODE_ALT_BIT   0
`define ACM_MODE_SCAN_BIT  10
`define ACM_MODE_MASK      16'h0401
`define ACM_PIN_COUNT      13
`define ACM_REF_MSB        15
`define ACM_REF_LSB        13

// ------------------------------------------------------------
// reset values and misc constants
// ------------------------------------------------------------
`define ACM_RST_REG16      16'h0000
`define ACM_RST_WORD       32'h0000_0000
`define ACM_SCAN_WRAP      4'hf
`define ACM_HTRANS_NONSEQ  2'b10
`define ACM_HRESP_OKAY     1'b0

`endif

// ---- acm_pkg.sv ----
// types shared by the converter control block
`default_nettype none
package acm_pkg;
    typedef enum logic [0:0] {
        ACM_SMP_IDLE,
        ACM_SMP_RUN
    } acm_smp_state_type;
    typedef logic [15:0] acm_reg16_type;
endpackage
`default_nettype wire

// ---- acm_clk_div.sv ----
// conversion clock tick generator dividing the instruction clock by code plus one
`timescale 1ns/1ps
`default_nettype none
module acm_clk_div #(
    parameter int DIV_W = 8
) (
    input  wire logic             hclk,     // instruction clock
    input  wire logic             hresetn,  // async reset, active low
    input  wire logic [DIV_W-1:0] div_code, // divider code
    output logic                  tick      // one-cycle pulse per period
);
    logic [DIV_W-1:0] cnt_ff;
    logic [DIV_W-1:0] nxt_cnt;
    logic             tick_ff;
    wire              wrap = (cnt_ff >= div_code);

    // a code change takes effect in the current period; >= avoids a long stall when shrinking
    assign nxt_cnt = wrap ? '0 : cnt_ff + 1'b1;
    assign tick    = tick_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_ff  <= '0;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            tick_ff <= wrap;
        end
    end
endmodule
`default_nettype wire

// ---- acm_scan_next.sv ----
// finds the next selected scan channel above the current one, wrapping to the lowest
`timescale 1ns/1ps
`default_nettype none
module acm_scan_next #(
    parameter int CH_N = 16
) (
    input  wire logic [CH_N-1:0]         sel_mask, // channels enabled for scan
    input  wire logic [$clog2(CH_N)-1:0] cur,      // channel just used
    output logic [$clog2(CH_N)-1:0]      nxt,      // next channel to use
    output logic                         any       // at least one channel selected
);
    localparam int IW = $clog2(CH_N);
    logic [CH_N-1:0] above;

    genvar g;
    generate
        for (g = 0; g < CH_N; g++) begin : g_above
            assign above[g] = sel_mask[g] && (g > int'(cur));
        end
    endgenerate

    assign any = |sel_mask;

    // downward loop so the lowest set bit wins
    always_comb begin
        nxt = cur;
        for (int i = CH_N - 1; i >= 0; i--) begin
            if (sel_mask[i]) begin
                nxt = IW'(i);
            end
        end
        if (|above) begin
            for (int i = CH_N - 1; i >= 0; i--) begin
                if (above[i]) begin
                    nxt = IW'(i);
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- acm_top.sv ----
// converter clock, sample timing, input multiplexer and scan control behind an ahb-lite slave
//
// Summary of operation
// - clock source bit set picks internal rc clock, clear picks divided system clock
// - five-bit sample field gives auto-sample time in conversion clock periods, 0..31
// - conversion clock period is instruction period times divider code plus one
// - bank b negative bit set routes input one, clear routes negative reference
// - bank a negative bit works the same way as the bank b bit
// - positive select codes 0..12 route external analog inputs 0..12
// - codes 13,14,15 route regulator output, half band gap, full band gap
// - bank a positive select decodes exactly like bank b positive select
// - top three pin config bits disable band gap, half band gap, regulator channels
// - pin config bit one means digital with port read, zero means analog sampled
// - top three scan bits add band gap, half band gap, regulator to the scan
// - lower thirteen scan bits add matching external channels to the scan
// - with scan enabled, bank a positive input steps through selected scan channels
// - alternate mode uses bank a first, then alternates bank b and bank a
//
// Our own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "acm_defines.svh"
module acm_top
    import acm_pkg::*;
#(
    parameter int DIV_W  = 8,
    parameter int SAMC_W = 5,
    parameter int SEL_W  = 5
) (
    input  wire logic                     hclk,            // instruction clock, 10 MHz
    input  wire logic                     hresetn,         // async reset, active low
    input  wire logic                     hsel,            // slave select
    input  wire logic [31:0]              haddr,           // byte address
    input  wire logic [1:0]               htrans,          // transfer type
    input  wire logic                     hwrite,          // write when high
    input  wire logic [2:0]               hsize,           // transfer size, word only
    input  wire logic [31:0]              hwdata,          // write data
    input  wire logic                     hready,          // bus ready
    output logic                          hreadyout,       // slave ready
    output logic                          hresp,           // always okay
    output logic [31:0]                   hrdata,          // read data
    input  wire logic                     rc_osc,          // internal rc oscillator level
    input  wire logic                     sample_start,    // pulse, begin auto-sample
    output logic                          conv_clk_tick,   // pulse per conversion clock period
    output logic                          sampling,        // auto-sample in progress
    output logic                          sample_end,      // pulse, sampling time elapsed
    output logic [SEL_W-1:0]              pos_sel,         // positive input code
    output logic                          neg_sel_an1,     // negative input is input one
    output logic                          bank_b_active,   // current sample uses bank b
    output logic [`ACM_PIN_COUNT-1:0]     pin_digital,     // per pin digital mode, port read on
    output logic [2:0]                    ref_disable      // bandgap, half bandgap, regulator off
);
    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    acm_reg16_type      timing_ff;
    acm_reg16_type      mux_ff;
    acm_reg16_type      pincfg_ff;
    acm_reg16_type      scansel_ff;
    acm_reg16_type      mode_ff;
    logic               wr_pend_ff;
    logic [3:0]         wr_idx_ff;
    logic [31:0]        hrdata_ff;
    logic               hreadyout_ff;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    wire         addr_take  = hsel && hready && (htrans == `ACM_HTRANS_NONSEQ);
    wire [3:0]   addr_idx   = haddr[`ACM_ADDR_MSB:`ACM_ADDR_LSB];
    wire         addr_hi_ok = (haddr[31:`ACM_ADDR_MSB+1] == '0);
    wire         rd_take    = addr_take && !hwrite;
    wire         wr_take    = addr_take && hwrite && addr_hi_ok;
    wire [15:0]  wdat       = hwdata[15:0];
    wire         wr_timing  = wr_pend_ff && (wr_idx_ff == `ACM_OFS_TIMING);
    wire         wr_mux     = wr_pend_ff && (wr_idx_ff == `ACM_OFS_MUX);
    wire         wr_pincfg  = wr_pend_ff && (wr_idx_ff == `ACM_OFS_PINCFG);
    wire         wr_scansel = wr_pend_ff && (wr_idx_ff == `ACM_OFS_SCANSEL);
    wire         wr_mode    = wr_pend_ff && (wr_idx_ff == `ACM_OFS_MODE);

    // ------------------------------------------------------------
    // field views
    // ------------------------------------------------------------
    wire              clk_src_rc  = timing_ff[`ACM_TIM_SRC_BIT];
    wire [SAMC_W-1:0] samc        = timing_ff[`ACM_TIM_SAMC_MSB:`ACM_TIM_SAMC_LSB];
    wire [DIV_W-1:0]  div_code    = timing_ff[`ACM_TIM_DIV_MSB:`ACM_TIM_DIV_LSB];
    wire              neg_b       = mux_ff[`ACM_MUX_NB_BIT];
    wire              neg_a       = mux_ff[`ACM_MUX_NA_BIT];
    wire [SEL_W-1:0]  pos_b       = mux_ff[`ACM_MUX_SB_MSB:`ACM_MUX_SB_LSB];
    wire [SEL_W-1:0]  pos_a       = mux_ff[`ACM_MUX_SA_MSB:`ACM_MUX_SA_LSB];
    wire              alt_en      = mode_ff[`ACM_MODE_ALT_BIT];
    wire              scan_en     = mode_ff[`ACM_MODE_SCAN_BIT];

    // ------------------------------------------------------------
    // conversion clock
    // ------------------------------------------------------------
    logic               div_tick;
    logic               rc_prev_ff;
    logic               tick_ff;
    wire                rc_tick  = rc_osc && !rc_prev_ff;
    wire                nxt_tick = clk_src_rc ? rc_tick : div_tick;

    acm_clk_div #(
        .DIV_W    (DIV_W)
    ) u_div (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .div_code (div_code),
        .tick     (div_tick)
    );

    // ------------------------------------------------------------
    // sample timer and multiplexer sequence
    // ------------------------------------------------------------
    acm_smp_state_type  state_ff;
    acm_smp_state_type  nxt_state;
    logic [SAMC_W-1:0]  smp_cnt_ff;
    logic [SAMC_W-1:0]  nxt_smp_cnt;
    logic               smp_end_ff;
    logic               alt_b_ff;
    logic [3:0]         scan_ptr_ff;
    logic [3:0]         scan_nxt;
    logic               scan_any;
    logic [SEL_W-1:0]   pos_sel_ff;
    logic               neg_sel_ff;
    logic               bank_b_ff;

    wire                smp_done    = (state_ff == ACM_SMP_RUN) && (smp_cnt_ff == samc);
    wire                seq_restart = wr_mode || wr_scansel;
    wire                use_b       = alt_en && alt_b_ff;
    wire                scan_step   = smp_done && scan_en && !use_b && scan_any;
    wire [3:0]          scan_cur    = seq_restart ? `ACM_SCAN_WRAP : scan_ptr_ff;
    wire [SEL_W-1:0]    pos_a_eff   = scan_en ? SEL_W'(scan_ptr_ff) : pos_a;
    // one decode serves both banks, so channel mapping cannot drift between them
    wire [SEL_W-1:0]    nxt_pos_sel = use_b ? pos_b : pos_a_eff;
    wire                nxt_neg_sel = use_b ? neg_b : neg_a;
    wire                nxt_alt_b   = seq_restart ? 1'b0 : (smp_done && alt_en) ? !alt_b_ff : alt_b_ff;

    acm_scan_next #(
        .CH_N     (16)
    ) u_scan (
        .sel_mask (scansel_ff),
        .cur      (scan_cur),
        .nxt      (scan_nxt),
        .any      (scan_any)
    );

    always_comb begin
        nxt_state   = state_ff;
        nxt_smp_cnt = smp_cnt_ff;
        case (state_ff)
            ACM_SMP_IDLE: begin
                if (sample_start) begin
                    nxt_state   = ACM_SMP_RUN;
                    nxt_smp_cnt = '0;
                end
            end
            ACM_SMP_RUN: begin
                if (smp_done) begin
                    nxt_state = ACM_SMP_IDLE;
                end else if (tick_ff) begin
                    nxt_smp_cnt = smp_cnt_ff + 1'b1;
                end
            end
            default: begin
                nxt_state   = ACM_SMP_IDLE;
                nxt_smp_cnt = '0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    wire [15:0]  status_word = {8'h00, neg_sel_ff, (state_ff == ACM_SMP_RUN), bank_b_ff, pos_sel_ff};
    logic [15:0] rd_word;

    always_comb begin
        rd_word = `ACM_RST_REG16;
        if (addr_hi_ok) begin
            case (addr_idx)
                `ACM_OFS_TIMING:  rd_word = timing_ff;
                `ACM_OFS_MUX:     rd_word = mux_ff;
                `ACM_OFS_PINCFG:  rd_word = pincfg_ff;
                `ACM_OFS_SCANSEL: rd_word = scansel_ff;
                `ACM_OFS_MODE:    rd_word = mode_ff;
                `ACM_OFS_STATUS:  rd_word = status_word;
                default:          rd_word = `ACM_RST_REG16;
            endcase
        end
    end

    // ------------------------------------------------------------
    // bus and register flops
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff   <= 1'b0;
            wr_idx_ff    <= '0;
            hrdata_ff    <= `ACM_RST_WORD;
            hreadyout_ff <= 1'b0;
        end else begin
            hreadyout_ff <= 1'b1;
            wr_pend_ff   <= wr_take;
            if (addr_take) begin
                wr_idx_ff <= addr_idx;
            end
            if (rd_take) begin
                hrdata_ff <= {16'h0000, rd_word};
            end
        end
    end

    // reserved and unimplemented bits are masked so they always read zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timing_ff  <= `ACM_RST_REG16;
            mux_ff     <= `ACM_RST_REG16;
            pincfg_ff  <= `ACM_RST_REG16;
            scansel_ff <= `ACM_RST_REG16;
            mode_ff    <= `ACM_RST_REG16;
        end else begin
            if (wr_timing) begin
                timing_ff <= wdat & `ACM_TIM_MASK;
            end
            if (wr_mux) begin
                mux_ff <= wdat & `ACM_MUX_MASK;
            end
            if (wr_pincfg) begin
                pincfg_ff <= wdat;
            end
            if (wr_scansel) begin
                scansel_ff <= wdat;
            end
            if (wr_mode) begin
                mode_ff <= wdat & `ACM_MODE_MASK;
            end
        end
    end

    // ------------------------------------------------------------
    // converter control flops
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rc_prev_ff <= 1'b0;
            tick_ff    <= 1'b0;
            state_ff   <= ACM_SMP_IDLE;
            smp_cnt_ff <= '0;
            smp_end_ff <= 1'b0;
        end else begin
            rc_prev_ff <= rc_osc;
            tick_ff    <= nxt_tick;
            state_ff   <= nxt_state;
            smp_cnt_ff <= nxt_smp_cnt;
            smp_end_ff <= smp_done;
        end
    end

    // the sequence moves on at the end of each sample so the next sample sees the new input
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            alt_b_ff    <= 1'b0;
            scan_ptr_ff <= '0;
            pos_sel_ff  <= '0;
            neg_sel_ff  <= 1'b0;
            bank_b_ff   <= 1'b0;
        end else begin
            alt_b_ff   <= nxt_alt_b;
            pos_sel_ff <= nxt_pos_sel;
            neg_sel_ff <= nxt_neg_sel;
            bank_b_ff  <= use_b;
            // with no channel selected the pointer holds, it must not jump to the wrap code
            if ((seq_restart && scan_any) || scan_step) begin
                scan_ptr_ff <= scan_nxt;
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign hreadyout     = hreadyout_ff;
    assign hresp         = `ACM_HRESP_OKAY;
    assign hrdata        = hrdata_ff;
    assign conv_clk_tick = tick_ff;
    assign sampling      = (state_ff == ACM_SMP_RUN);
    assign sample_end    = smp_end_ff;
    assign pos_sel       = pos_sel_ff;
    assign neg_sel_an1   = neg_sel_ff;
    assign bank_b_active = bank_b_ff;
    assign pin_digital   = pincfg_ff[`ACM_PIN_COUNT-1:0];
    assign ref_disable   = pincfg_ff[`ACM_REF_MSB:`ACM_REF_LSB];

endmodule
`default_nettype wire

// ---- acm_top_asserts.sv ----
// port-level assertions for the converter control block
`timescale 1ns/1ps
`default_nettype none
module acm_chk (
    input wire logic        hclk,          // instruction clock
    input wire logic        hresetn,       // async reset, active low
    input wire logic        hreadyout,     // slave ready
    input wire logic        hresp,         // response
    input wire logic [31:0] hrdata,        // read data
    input wire logic        sample_start,  // start pulse
    input wire logic        conv_clk_tick, // conversion clock pulse
    input wire logic        sampling,      // sampling level
    input wire logic        sample_end,    // end pulse
    input wire logic        bank_b_active  // bank b in use
);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_resp_okay: assert property (hresp == 1'b0)
        else $error("response is not okay");
    a_ready_zero_wait: assert property ($past(hresetn) |-> hreadyout)
        else $error("slave inserted a wait state");
    a_rdata_upper_zero: assert property (hrdata[31:16] == 16'h0000)
        else $error("upper read data not zero");
    a_end_single_pulse: assert property (sample_end |=> !sample_end)
        else $error("sample end longer than one cycle");
    a_end_closes_sampling: assert property (sample_end |-> !sampling && $past(sampling))
        else $error("sample end not at sampling fall");
    a_start_opens_sampling: assert property (sample_start && !sampling |=> sampling && !sample_end)
        else $error("idle start did not begin sampling");
    a_sampling_has_cause: assert property ($rose(sampling) |-> $past(sample_start))
        else $error("sampling began without start");
    a_bank_b_after_end: assert property ($rose(bank_b_active) |->
        sample_end || $past(sample_end) || $past(sample_end, 2))
        else $error("bank b selected without a sample end");

    // ------------------------------------------------------------
    // main scenarios reached
    // ------------------------------------------------------------
    c_sample_end: cover property (sample_end);
    c_bank_b: cover property ($rose(bank_b_active));
    c_tick_pulse: cover property (conv_clk_tick ##1 !conv_clk_tick);
endmodule

bind acm_top acm_chk acm_chk_inst (
    .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .sample_start(sample_start), .conv_clk_tick(conv_clk_tick), .sampling(sampling),
    .sample_end(sample_end), .bank_b_active(bank_b_active)
);
`default_nettype wire

// ---- test_adc_clock_mux_scan_control.sv ----
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
`include "acm_defines.svh"
module test_adc_clock_mux_scan_control
    import acm_pkg::*;
;
    logic        hclk, hresetn, hsel, hwrite, rc_osc, sample_start;
    logic        hreadyout, hresp, conv_clk_tick, sampling, sample_end, neg_sel_an1, bank_b_active;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize, ref_disable;
    logic [4:0]  pos_sel;
    logic [12:0] pin_digital;
    int          fails, compares;

    acm_top acm_top_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .rc_osc(rc_osc), .sample_start(sample_start), .conv_clk_tick(conv_clk_tick),
        .sampling(sampling), .sample_end(sample_end), .pos_sel(pos_sel), .neg_sel_an1(neg_sel_an1),
        .bank_b_active(bank_b_active), .pin_digital(pin_digital), .ref_disable(ref_disable)
    );

    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    // ------------------------------------------------------------
    // shared bus and compare tasks
    // ------------------------------------------------------------
    function automatic logic [31:0] reg_addr(input logic [3:0] o);
        return {26'h0, o, 2'b00};
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // returns just after the edge at which ready was sampled high
    task automatic wait_ready;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 50) begin
            @(posedge hclk);
            n++;
        end
        if (hreadyout !== 1'b1) begin
            check(hreadyout, 1'b1);
        end
    endtask

    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= `ACM_HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] rd;
        xfer(1'b1, a, d, rd);
    endtask

    task automatic rdc(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] rd;
        xfer(1'b0, a, 32'h0, rd);
        check(rd, e);
        check(hresp, `ACM_HRESP_OKAY);
    endtask

    // pulses a start and counts the cycles that sampling stays high
    task automatic smp(output int n);
        n = 0;
        sample_start <= 1'b1;
        @(posedge hclk);
        sample_start <= 1'b0;
        @(posedge hclk);
        while (sampling === 1'b1 && n < 2000) begin
            n++;
            @(posedge hclk);
        end
        check(sample_end, 1'b1);
        repeat (3) @(posedge hclk);
    endtask

    task automatic next_tick(output int n);
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (conv_clk_tick !== 1'b1 && n < 600);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_registers;
        logic [3:0]  ofs [7] = '{`ACM_OFS_STATUS, `ACM_OFS_TIMING, `ACM_OFS_MUX, `ACM_OFS_PINCFG,
                                 `ACM_OFS_SCANSEL, `ACM_OFS_MODE, 4'h6};
        logic [15:0] wv [7]  = '{16'hffff, 16'h9f3f, 16'h8f8f, 16'hffff, 16'hffff, 16'hffff, 16'hffff};
        logic [15:0] ex [7]  = '{16'h0000, 16'h9f3f, 16'h8f8f, 16'hffff, 16'hffff, 16'h0401, 16'h0000};
        for (int i = 0; i < 7; i++) begin
            rdc(reg_addr(ofs[i]), `ACM_RST_WORD);
            wr(reg_addr(ofs[i]), {16'hffff, wv[i]});
            rdc(reg_addr(ofs[i]), {16'h0, ex[i]});
        end
        check({ref_disable, pin_digital}, 16'hffff);
        wr(reg_addr(`ACM_OFS_PINCFG), 32'h0000_51c5);
        @(posedge hclk);
        check({ref_disable, pin_digital}, 16'h51c5);
        for (int i = 1; i < 6; i++) begin
            wr(reg_addr(ofs[i]), 32'h0);
        end
    endtask

    task automatic t_divider;
        logic [7:0] codes [3] = '{8'h00, 8'h03, 8'h3f};
        int         g;
        foreach (codes[i]) begin
            wr(reg_addr(`ACM_OFS_TIMING), {24'h0, codes[i]});
            next_tick(g);
            next_tick(g);
            next_tick(g);
            check(g, codes[i] + 1);
        end
    endtask

    // divider of one would give forty ticks here, the rc input gives three
    task automatic t_rc_source;
        int k;
        k = 0;
        wr(reg_addr(`ACM_OFS_TIMING), 32'h0000_8001);
        @(posedge hclk);
        for (int i = 0; i < 80; i++) begin
            rc_osc <= (i % 20) < 10 && i < 60;
            @(posedge hclk);
            if (conv_clk_tick === 1'b1) begin
                k++;
            end
        end
        check(k, 3);
        rc_osc <= 1'b0;
    endtask

    task automatic t_sample_time;
        logic [4:0] s [3] = '{5'd0, 5'd1, 5'd31};
        int         n;
        foreach (s[i]) begin
            wr(reg_addr(`ACM_OFS_TIMING), {19'h0, s[i], 8'h00});
            smp(n);
            check(n, s[i] + 1);
        end
    endtask

    task automatic t_mux_codes;
        for (int c = 0; c < 16; c++) begin
            wr(reg_addr(`ACM_OFS_MUX), {24'h0, c[0], 2'b00, c[4:0]});
            repeat (2) @(posedge hclk);
            check(pos_sel, c[4:0]);
            check(neg_sel_an1, c[0]);
        end
    endtask

    task automatic t_alternate;
        int n;
        wr(reg_addr(`ACM_OFS_MUX), 32'h0000_8d03);
        wr(reg_addr(`ACM_OFS_MODE), 32'h0000_0001);
        repeat (2) @(posedge hclk);
        for (int i = 0; i < 4; i++) begin
            check({bank_b_active, neg_sel_an1, pos_sel}, i[0] ? 7'h6d : 7'h03);
            rdc(reg_addr(`ACM_OFS_STATUS), i[0] ? 32'h0000_00ad : 32'h0000_0003);
            smp(n);
        end
    endtask

    // bank a code 3 is still set, scanning must override it
    task automatic t_scan;
        logic [4:0] seq [6] = '{5'd0, 5'd4, 5'd13, 5'd14, 5'd15, 5'd0};
        int         n;
        wr(reg_addr(`ACM_OFS_SCANSEL), 32'h0000_e011);
        wr(reg_addr(`ACM_OFS_MODE), 32'h0000_0400);
        repeat (2) @(posedge hclk);
        foreach (seq[i]) begin
            check(pos_sel, seq[i]);
            smp(n);
        end
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        rc_osc = 1'b0;
        sample_start = 1'b0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        t_registers();
        t_divider();
        t_rc_source();
        t_sample_time();
        wr(reg_addr(`ACM_OFS_TIMING), 32'h0);
        t_mux_codes();
        t_alternate();
        t_scan();
        complete_run();
    end

    initial begin
        repeat (20000) @(posedge hclk);
        fails++;
        complete_run();
    end
endmodule
`default_nettype wire
